// File: lagc_pkg.sv
package lagc_pkg;
   // Register indices; byte address is four times the index
   localparam logic [7:0] LAGC_IDX_CTRL_A = 8'h56;
   localparam logic [7:0] LAGC_IDX_CTRL_B = 8'h57;
   localparam logic [7:0] LAGC_IDX_MAX_GAIN = 8'h58;
   localparam logic [7:0] LAGC_IDX_ATTACK = 8'h59;
   localparam int LAGC_ADDR_W = 12;
   localparam logic [11:0] LAGC_ADDR_CTRL_A = {2'h0, LAGC_IDX_CTRL_A, 2'h0};
   localparam logic [11:0] LAGC_ADDR_CTRL_B = {2'h0, LAGC_IDX_CTRL_B, 2'h0};
   localparam logic [11:0] LAGC_ADDR_MAX_GAIN = {2'h0, LAGC_IDX_MAX_GAIN, 2'h0};
   localparam logic [11:0] LAGC_ADDR_ATTACK = {2'h0, LAGC_IDX_ATTACK, 2'h0};
   // Field positions
   localparam int LAGC_EN_BIT = 7;
   localparam int LAGC_TGT_LSB = 4;
   localparam int LAGC_GHYS_LSB = 0;
   localparam int LAGC_HYS_LSB = 6;
   localparam int LAGC_NTH_LSB = 1;
   localparam int LAGC_MAXG_LSB = 0;
   localparam int LAGC_ATK_LSB = 3;
   localparam int LAGC_ASC_LSB = 0;
   // Writable masks; all other bits are reserved and read zero
   localparam logic [7:0] LAGC_MASK_CTRL_A = 8'hf3;
   localparam logic [7:0] LAGC_MASK_CTRL_B = 8'hfe;
   localparam logic [7:0] LAGC_MASK_MAX_GAIN = 8'h7f;
   localparam logic [7:0] LAGC_MASK_ATTACK = 8'hff;
   // Reset values
   localparam logic [7:0] LAGC_RST_CTRL_A = 8'h00;
   localparam logic [7:0] LAGC_RST_CTRL_B = 8'h00;
   localparam logic [7:0] LAGC_RST_MAX_GAIN = 8'h7f;
   localparam logic [7:0] LAGC_RST_ATTACK = 8'h00;
   // Decoded figures, in tenths of dB, half-dB steps or word clocks
   localparam logic [6:0] LAGC_MAXG_TOP = 7'h74;
   localparam logic [9:0] LAGC_NTH_BASE = 10'h12c;
   localparam logic [9:0] LAGC_NTH_STEP = 10'h014;
   localparam logic [17:0] LAGC_ATK_UNIT = 18'h00020;
   // AXI responses
   localparam logic [1:0] LAGC_RESP_OKAY = 2'h0;
   localparam logic [1:0] LAGC_RESP_SLVERR = 2'h2;
endpackage

// File: lagc_regs.sv
// Behaviour
// - Bit 7 of control A enables the left gain loop, and it resets to off.
// - Target codes 0 to 4 select -5.5, -8.0, -10.0, -12.0 and -14.0 dBFS.
// - Target codes 5, 6 and 7 select -17.0, -20.0 and -24.0 dBFS.
// - Gain hysteresis codes give off, 0.5, 1.0 and 1.5 dB.
// - Control B bits 7-6 give 1.0, 2.0, 4.0 dB hysteresis, code 3 is off.
// - Noise threshold zero is off, else -30 dB falling 2 dB per code.
// - Maximum gain is 0.5 dB per code up to 58.0 dB, resetting to all ones.
// - Maximum gain codes above the top step still cap at 58.0 dB.
// - Base attack time is (2N+1) times 32 word clocks for code N.
// - Attack scale code K gives a factor of two to the power K.
// - Reserved bits read zero and writes to them are dropped.
`timescale 1ns/10ps
`default_nettype none
module lagc_regs (
   input  wire logic                              sys_clk,
   input  wire logic                              nrst,
   input  wire logic [lagc_pkg::LAGC_ADDR_W-1:0]  s_axi_awaddr,
   input  wire logic                              s_axi_awvalid,
   output logic                                   s_axi_awready,
   input  wire logic [31:0]                       s_axi_wdata,
   input  wire logic [3:0]                        s_axi_wstrb,
   input  wire logic                              s_axi_wvalid,
   output logic                                   s_axi_wready,
   output logic [1:0]                             s_axi_bresp,
   output logic                                   s_axi_bvalid,
   input  wire logic                              s_axi_bready,
   input  wire logic [lagc_pkg::LAGC_ADDR_W-1:0]  s_axi_araddr,
   input  wire logic                              s_axi_arvalid,
   output logic                                   s_axi_arready,
   output logic [31:0]                            s_axi_rdata,
   output logic [1:0]                             s_axi_rresp,
   output logic                                   s_axi_rvalid,
   input  wire logic                              s_axi_rready,
   output logic                                   agc_enable,
   output logic [8:0]                             target_level_tenth_db,
   output logic [4:0]                             gain_hyst_tenth_db,
   output logic [5:0]                             hyst_tenth_db,
   output logic                                   noise_gate_on,
   output logic [9:0]                             noise_thresh_tenth_db,
   output logic [6:0]                             max_gain_half_db,
   output logic [17:0]                            attack_base_wclk,
   output logic [7:0]                             attack_scale,
   output logic [17:0]                            attack_eff_wclk
);
   import lagc_pkg::*;

   logic [7:0]             ctrl_a_reg;
   logic [7:0]             ctrl_b_reg;
   logic [7:0]             max_gain_reg;
   logic [7:0]             attack_reg;
   logic                   aw_held_reg;
   logic                   w_held_reg;
   logic [LAGC_ADDR_W-1:0] awaddr_reg;
   logic [7:0]             wdata_reg;
   logic                   wstrb0_reg;
   logic                   bvalid_reg;
   logic [1:0]             bresp_reg;
   logic                   rvalid_reg;
   logic [1:0]             rresp_reg;
   logic [31:0]            rdata_reg;
   logic                   enable_reg;
   logic [8:0]             target_reg;
   logic [4:0]             ghys_reg;
   logic [5:0]             hys_reg;
   logic                   ngate_reg;
   logic [9:0]             nthr_reg;
   logic [6:0]             maxg_reg;
   logic [17:0]            atk_base_reg;
   logic [7:0]             atk_scale_reg;
   logic [17:0]            atk_eff_reg;

   // Write channel: address and data may arrive in either order
   wire                   aw_fire = s_axi_awvalid & s_axi_awready;
   wire                   w_fire = s_axi_wvalid & s_axi_wready;
   wire                   aw_have = aw_held_reg | aw_fire;
   wire                   w_have = w_held_reg | w_fire;
   wire                   do_write = aw_have & w_have & ~bvalid_reg;
   wire [LAGC_ADDR_W-1:0] wr_addr = aw_held_reg ? awaddr_reg : s_axi_awaddr;
   wire [7:0]             wr_byte = w_held_reg ? wdata_reg : s_axi_wdata[7:0];
   wire                   wr_lane0 = w_held_reg ? wstrb0_reg : s_axi_wstrb[0];
   wire                   wr_sel_a = wr_addr == LAGC_ADDR_CTRL_A;
   wire                   wr_sel_b = wr_addr == LAGC_ADDR_CTRL_B;
   wire                   wr_sel_m = wr_addr == LAGC_ADDR_MAX_GAIN;
   wire                   wr_sel_t = wr_addr == LAGC_ADDR_ATTACK;
   wire                   wr_hit = wr_sel_a | wr_sel_b | wr_sel_m | wr_sel_t;
   wire                   wr_en = do_write & wr_lane0;

   assign s_axi_awready = ~aw_held_reg & ~bvalid_reg;
   assign s_axi_wready = ~w_held_reg & ~bvalid_reg;
   assign s_axi_bvalid = bvalid_reg;
   assign s_axi_bresp = bresp_reg;

   // Reserved bits are masked on the way in, so they always read zero
   wire [7:0] ctrl_a_next = wr_en & wr_sel_a ? wr_byte & LAGC_MASK_CTRL_A
                                             : ctrl_a_reg;
   wire [7:0] ctrl_b_next = wr_en & wr_sel_b ? wr_byte & LAGC_MASK_CTRL_B
                                             : ctrl_b_reg;
   wire [7:0] max_gain_next = wr_en & wr_sel_m
                              ? wr_byte & LAGC_MASK_MAX_GAIN
                              : max_gain_reg;
   wire [7:0] attack_next = wr_en & wr_sel_t ? wr_byte & LAGC_MASK_ATTACK
                                             : attack_reg;

   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         ctrl_a_reg <= LAGC_RST_CTRL_A;
         ctrl_b_reg <= LAGC_RST_CTRL_B;
         max_gain_reg <= LAGC_RST_MAX_GAIN;
         attack_reg <= LAGC_RST_ATTACK;
      end else begin
         ctrl_a_reg <= ctrl_a_next;
         ctrl_b_reg <= ctrl_b_next;
         max_gain_reg <= max_gain_next;
         attack_reg <= attack_next;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         aw_held_reg <= 1'b0;
         w_held_reg <= 1'b0;
         awaddr_reg <= '0;
         wdata_reg <= 8'h00;
         wstrb0_reg <= 1'b0;
      end else begin
         aw_held_reg <= aw_have & ~do_write;
         w_held_reg <= w_have & ~do_write;
         if (aw_fire) begin
            awaddr_reg <= s_axi_awaddr;
         end
         if (w_fire) begin
            wdata_reg <= s_axi_wdata[7:0];
            wstrb0_reg <= s_axi_wstrb[0];
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         bvalid_reg <= 1'b0;
         bresp_reg <= LAGC_RESP_OKAY;
      end else if (do_write) begin
         bvalid_reg <= 1'b1;
         bresp_reg <= wr_hit ? LAGC_RESP_OKAY : LAGC_RESP_SLVERR;
      end else if (s_axi_bready) begin
         bvalid_reg <= 1'b0;
      end
   end

   // Read channel: one read in flight, answered one cycle after acceptance
   wire       ar_fire = s_axi_arvalid & s_axi_arready;
   wire       rd_sel_a = s_axi_araddr == LAGC_ADDR_CTRL_A;
   wire       rd_sel_b = s_axi_araddr == LAGC_ADDR_CTRL_B;
   wire       rd_sel_m = s_axi_araddr == LAGC_ADDR_MAX_GAIN;
   wire       rd_sel_t = s_axi_araddr == LAGC_ADDR_ATTACK;
   wire       rd_hit = rd_sel_a | rd_sel_b | rd_sel_m | rd_sel_t;
   wire [7:0] rd_byte = ({8{rd_sel_a}} & ctrl_a_reg)
                      | ({8{rd_sel_b}} & ctrl_b_reg)
                      | ({8{rd_sel_m}} & max_gain_reg)
                      | ({8{rd_sel_t}} & attack_reg);

   assign s_axi_arready = ~rvalid_reg;
   assign s_axi_rvalid = rvalid_reg;
   assign s_axi_rdata = rdata_reg;
   assign s_axi_rresp = rresp_reg;

   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         rvalid_reg <= 1'b0;
         rresp_reg <= LAGC_RESP_OKAY;
         rdata_reg <= 32'h00000000;
      end else if (ar_fire) begin
         rvalid_reg <= 1'b1;
         rresp_reg <= rd_hit ? LAGC_RESP_OKAY : LAGC_RESP_SLVERR;
         rdata_reg <= {24'h000000, rd_byte};
      end else if (s_axi_rready) begin
         rvalid_reg <= 1'b0;
      end
   end

   // Field decode into units the gain loop consumes
   wire [2:0] tgt_code = ctrl_a_reg[LAGC_TGT_LSB +: 3];
   wire [1:0] ghys_code = ctrl_a_reg[LAGC_GHYS_LSB +: 2];
   wire [1:0] hys_code = ctrl_b_reg[LAGC_HYS_LSB +: 2];
   wire [4:0] nth_code = ctrl_b_reg[LAGC_NTH_LSB +: 5];
   wire [6:0] maxg_code = max_gain_reg[LAGC_MAXG_LSB +: 7];
   wire [4:0] atk_code = attack_reg[LAGC_ATK_LSB +: 5];
   wire [2:0] asc_code = attack_reg[LAGC_ASC_LSB +: 3];

   logic [8:0] target_next;
   always_comb begin
      unique case (tgt_code)
         3'h0: target_next = 9'h037;
         3'h1: target_next = 9'h050;
         3'h2: target_next = 9'h064;
         3'h3: target_next = 9'h078;
         3'h4: target_next = 9'h08c;
         // Upper codes taken in ascending order of attenuation
         3'h5: target_next = 9'h0aa;
         3'h6: target_next = 9'h0c8;
         3'h7: target_next = 9'h0f0;
      endcase
   end

   wire [4:0]  ghys_next = 5'(ghys_code) * 5'h05;
   wire [5:0]  hys_next = hys_code == 2'h3 ? 6'h00
                        : 6'(6'h0a << hys_code);
   wire        ngate_next = nth_code != 5'h00;
   wire [9:0]  nthr_next = ngate_next
                           ? 10'(LAGC_NTH_BASE
                                 + LAGC_NTH_STEP * 10'(nth_code - 5'h01))
                           : 10'h000;
   // Over-range codes clamp rather than wrap, so a stray write is harmless
   wire [6:0]  maxg_next = maxg_code > LAGC_MAXG_TOP ? LAGC_MAXG_TOP
                                                     : maxg_code;
   wire [17:0] atk_base_next = 18'({atk_code, 1'b1}) * LAGC_ATK_UNIT;
   wire [7:0]  atk_scale_next = 8'(8'h01 << asc_code);
   // Largest product is 63*32*128, which fits eighteen bits
   wire [17:0] atk_eff_next = 18'(atk_base_next << asc_code);

   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         enable_reg <= 1'b0;
         target_reg <= 9'h000;
         ghys_reg <= 5'h00;
         hys_reg <= 6'h00;
         ngate_reg <= 1'b0;
         nthr_reg <= 10'h000;
         maxg_reg <= 7'h00;
         atk_base_reg <= 18'h00000;
         atk_scale_reg <= 8'h00;
         atk_eff_reg <= 18'h00000;
      end else begin
         enable_reg <= ctrl_a_reg[LAGC_EN_BIT];
         target_reg <= target_next;
         ghys_reg <= ghys_next;
         hys_reg <= hys_next;
         ngate_reg <= ngate_next;
         nthr_reg <= nthr_next;
         maxg_reg <= maxg_next;
         atk_base_reg <= atk_base_next;
         atk_scale_reg <= atk_scale_next;
         atk_eff_reg <= atk_eff_next;
      end
   end

   assign agc_enable = enable_reg;
   assign target_level_tenth_db = target_reg;
   assign gain_hyst_tenth_db = ghys_reg;
   assign hyst_tenth_db = hys_reg;
   assign noise_gate_on = ngate_reg;
   assign noise_thresh_tenth_db = nthr_reg;
   assign max_gain_half_db = maxg_reg;
   assign attack_base_wclk = atk_base_reg;
   assign attack_scale = atk_scale_reg;
   assign attack_eff_wclk = atk_eff_reg;

   enable_follow_a: assert property (@(posedge sys_clk)
      disable iff (!nrst) agc_enable == $past(ctrl_a_reg[LAGC_EN_BIT]))
      else $error("Enable output does not follow control bit");

   enable_reset_a: assert property (@(posedge sys_clk)
      $rose(nrst) |-> !agc_enable)
      else $error("Enable not off after reset");

   // Decoded outputs hold reset zeros for one edge, so code checks skip it
   target_low_a: assert property (@(posedge sys_clk)
      disable iff (!nrst) $past(nrst) && $past(tgt_code) == 3'h0
      |-> target_level_tenth_db == 9'h037)
      else $error("Target code zero not at -5.5 dBFS");

   target_mid_a: assert property (@(posedge sys_clk)
      disable iff (!nrst) $past(tgt_code) == 3'h4
      |-> target_level_tenth_db == 9'h08c)
      else $error("Target code four not at -14.0 dBFS");

   target_high_a: assert property (@(posedge sys_clk)
      disable iff (!nrst) $past(tgt_code) == 3'h7
      |-> target_level_tenth_db == 9'h0f0)
      else $error("Top target code not at -24.0 dBFS");

   gain_hyst_a: assert property (@(posedge sys_clk)
      disable iff (!nrst) $past(ghys_code) == 2'h3
      |-> gain_hyst_tenth_db == 5'h0f)
      else $error("Gain hysteresis code three not 1.5 dB");

   gain_hyst_off_a: assert property (@(posedge sys_clk)
      disable iff (!nrst) $past(ghys_code) == 2'h0
      |-> gain_hyst_tenth_db == 5'h00)
      else $error("Gain hysteresis code zero not off");

   hyst_off_a: assert property (@(posedge sys_clk)
      disable iff (!nrst) $past(nrst)
      |-> ($past(hys_code) == 2'h3) == (hyst_tenth_db == 6'h00))
      else $error("Hysteresis disable mismatch");

   noise_gate_a: assert property (@(posedge sys_clk)
      disable iff (!nrst) $past(nth_code) == 5'h1f
      |-> noise_gate_on && noise_thresh_tenth_db == 10'h384)
      else $error("Noise threshold code 31 not -90 dB");

   noise_off_a: assert property (@(posedge sys_clk)
      disable iff (!nrst) $past(nth_code) == 5'h00
      |-> !noise_gate_on && noise_thresh_tenth_db == 10'h000)
      else $error("Noise gate not off at code zero");

   max_pass_a: assert property (@(posedge sys_clk)
      disable iff (!nrst) $past(nrst) && $past(maxg_code) <= LAGC_MAXG_TOP
      |-> max_gain_half_db == $past(maxg_code))
      else $error("Maximum gain code not passed through");

   max_over_a: assert property (@(posedge sys_clk)
      disable iff (!nrst) $past(nrst) && $past(maxg_code) > LAGC_MAXG_TOP
      |-> max_gain_half_db == LAGC_MAXG_TOP)
      else $error("Over-range maximum gain code not held at 58 dB");

   max_clamp_a: assert property (@(posedge sys_clk)
      disable iff (!nrst) max_gain_half_db <= LAGC_MAXG_TOP)
      else $error("Maximum gain exceeds 58 dB");

   max_reset_a: assert property (@(posedge sys_clk)
      !nrst |=> max_gain_reg == LAGC_RST_MAX_GAIN
                && ctrl_a_reg == LAGC_RST_CTRL_A)
      else $error("Reset values wrong");

   reserved_zero_a: assert property (@(posedge sys_clk)
      disable iff (!nrst)
      ctrl_a_reg[3:2] == 2'h0 && !ctrl_b_reg[0] && !max_gain_reg[7])
      else $error("Reserved bit set");

   rdata_upper_a: assert property (@(posedge sys_clk)
      disable iff (!nrst) s_axi_rdata[31:8] == 24'h000000)
      else $error("Read data upper bits not zero");

   attack_eff_a: assert property (@(posedge sys_clk)
      disable iff (!nrst)
      attack_eff_wclk == 18'(attack_base_wclk * attack_scale))
      else $error("Effective attack time not base times scale");

   attack_base_a: assert property (@(posedge sys_clk)
      disable iff (!nrst) $past(atk_code) == 5'h1f
      |-> attack_base_wclk == 18'h007e0)
      else $error("Attack code 31 not 63 times 32");

   attack_min_a: assert property (@(posedge sys_clk)
      disable iff (!nrst) $past(nrst) && $past(atk_code) == 5'h00
      |-> attack_base_wclk == LAGC_ATK_UNIT)
      else $error("Attack code zero not 32 word clocks");

   attack_scale_a: assert property (@(posedge sys_clk)
      disable iff (!nrst) $past(asc_code) == 3'h7
      |-> attack_scale == 8'h80)
      else $error("Scale code seven not 128");

   write_resp_a: assert property (@(posedge sys_clk)
      disable iff (!nrst)
      do_write |=> s_axi_bvalid && !s_axi_awready && !s_axi_wready)
      else $error("Write response not raised after write");

   read_resp_a: assert property (@(posedge sys_clk)
      disable iff (!nrst) ar_fire |=> s_axi_rvalid && !s_axi_arready)
      else $error("Read response not raised after read");

endmodule
`default_nettype wire

// File: lagc_regs_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module lagc_regs_tb_top;
   import lagc_pkg::*;
   logic        sys_clk, nrst;
   logic [11:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0]  s_axi_wstrb;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic        s_axi_rvalid, s_axi_rready, agc_enable, noise_gate_on;
   logic [8:0]  target_level_tenth_db;
   logic [4:0]  gain_hyst_tenth_db;
   logic [5:0]  hyst_tenth_db;
   logic [9:0]  noise_thresh_tenth_db;
   logic [6:0]  max_gain_half_db;
   logic [17:0] attack_base_wclk, attack_eff_wclk;
   logic [7:0]  attack_scale;
   int          err_count, tests_run;
   logic [8:0]  tgt_tab [8] = '{9'h37, 9'h50, 9'h64, 9'h78,
                                9'h8c, 9'haa, 9'hc8, 9'hf0};
   logic [5:0]  hys_tab [4] = '{6'ha, 6'h14, 6'h28, 6'h0};
   logic [4:0]  nth_tab [4] = '{5'h0, 5'h1, 5'h2, 5'h1f};
   logic [7:0]  mg_tab [6]  = '{8'h0, 8'h1, 8'h73, 8'h74, 8'h75, 8'h7f};

   lagc_regs dut (.sys_clk, .nrst, .s_axi_awaddr, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
      .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .agc_enable,
      .target_level_tenth_db, .gain_hyst_tenth_db, .hyst_tenth_db,
      .noise_gate_on, .noise_thresh_tenth_db, .max_gain_half_db,
      .attack_base_wclk, .attack_scale, .attack_eff_wclk);

   initial begin
      sys_clk = 1'b0;
      forever #2 sys_clk = ~sys_clk;
   end

   task automatic test_done;
      $display("tests_run %0d err_count %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] e,
                      input logic [31:0] g);
      tests_run++;
      if (g !== e) begin
         $display("ERROR %s expected %h seen %h", nm, e, g);
         err_count++;
      end
   endtask

   task automatic tick(inout int n);
      n++;
      if (n > 40) begin
         err_count++;
         test_done();
      end
   endtask

   // Readies are sampled at the falling edge, where they have settled
   task automatic wr_chk(input logic [11:0] a, input logic [31:0] d,
                         input logic [3:0] s, input logic [1:0] er);
      logic aw_ok, w_ok;
      int   n;
      aw_ok = 1'b0;
      w_ok = 1'b0;
      n = 0;
      @(posedge sys_clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_wstrb <= s;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      forever begin
         @(negedge sys_clk);
         if (s_axi_awvalid && s_axi_awready) aw_ok = 1'b1;
         if (s_axi_wvalid && s_axi_wready) w_ok = 1'b1;
         if (s_axi_bvalid === 1'b1) break;
         @(posedge sys_clk);
         if (aw_ok) s_axi_awvalid <= 1'b0;
         if (w_ok) s_axi_wvalid <= 1'b0;
         tick(n);
      end
      chk("bresp", 32'(er), 32'(s_axi_bresp));
      @(posedge sys_clk);
      s_axi_bready <= 1'b0;
   endtask

   task automatic rd_chk(input logic [11:0] a, input logic [31:0] ed,
                         input logic [1:0] er);
      int n;
      n = 0;
      @(posedge sys_clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      forever begin
         @(negedge sys_clk);
         if (s_axi_rvalid === 1'b1) break;
         @(posedge sys_clk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
         tick(n);
      end
      chk("rdata", ed, s_axi_rdata);
      chk("rresp", 32'(er), 32'(s_axi_rresp));
      @(posedge sys_clk);
      s_axi_rready <= 1'b0;
   endtask

   // Decoded outputs trail the register by one clock
   task automatic settle;
      repeat (2) @(posedge sys_clk);
   endtask

   task automatic test_reset;
      rd_chk(LAGC_ADDR_CTRL_A, 32'h0, LAGC_RESP_OKAY);
      rd_chk(LAGC_ADDR_CTRL_B, 32'h0, LAGC_RESP_OKAY);
      rd_chk(LAGC_ADDR_MAX_GAIN, 32'h7f, LAGC_RESP_OKAY);
      rd_chk(LAGC_ADDR_ATTACK, 32'h0, LAGC_RESP_OKAY);
      chk("enable", 32'h0, 32'(agc_enable));
      chk("max_gain", 32'h74, 32'(max_gain_half_db));
      chk("target", 32'h37, 32'(target_level_tenth_db));
      chk("hyst", 32'ha, 32'(hyst_tenth_db));
      chk("eff", 32'h20, 32'(attack_eff_wclk));
      $display("test_reset done");
   endtask

   // Reserved bits go out as zero, as software must
   task automatic test_ctrl_a;
      logic [7:0]  d;
      logic [31:0] w;
      for (int c = 0; c < 8; c++) begin
         d = {c[0], c[2:0], 2'h0, c[1:0]};
         w = {24'h0, d};
         wr_chk(LAGC_ADDR_CTRL_A, w, 4'h1, LAGC_RESP_OKAY);
         settle();
         rd_chk(LAGC_ADDR_CTRL_A, w & 32'hf3, LAGC_RESP_OKAY);
         chk("enable", 32'(c[0]), 32'(agc_enable));
         chk("target", 32'(tgt_tab[c]),
             32'(target_level_tenth_db));
         chk("ghys", 32'(c[1:0]) * 32'h5, 32'(gain_hyst_tenth_db));
      end
      $display("test_ctrl_a done");
   endtask

   task automatic test_ctrl_b;
      logic [7:0]  d;
      logic [4:0]  n;
      logic [31:0] w;
      for (int i = 0; i < 4; i++) begin
         n = nth_tab[i];
         d = {i[1:0], n, 1'b0};
         w = {24'h0, d};
         wr_chk(LAGC_ADDR_CTRL_B, w, 4'h1, LAGC_RESP_OKAY);
         settle();
         rd_chk(LAGC_ADDR_CTRL_B, w & 32'hfe, LAGC_RESP_OKAY);
         chk("hyst", 32'(hys_tab[i]), 32'(hyst_tenth_db));
         chk("gate", 32'(n != 5'h0), 32'(noise_gate_on));
         chk("thresh", (n == 5'h0) ? 32'h0 : 32'h12c + 32'h14 * (32'(n) - 1),
             32'(noise_thresh_tenth_db));
      end
      $display("test_ctrl_b done");
   endtask

   task automatic test_max_gain;
      logic [7:0]  d;
      logic [31:0] w;
      for (int i = 0; i < 6; i++) begin
         d = mg_tab[i];
         w = {24'h0, d};
         wr_chk(LAGC_ADDR_MAX_GAIN, w, 4'h1, LAGC_RESP_OKAY);
         settle();
         rd_chk(LAGC_ADDR_MAX_GAIN, w & 32'h7f, LAGC_RESP_OKAY);
         chk("max_gain", (d[6:0] > 7'h74) ? 32'h74 : 32'(d[6:0]),
             32'(max_gain_half_db));
      end
      $display("test_max_gain done");
   endtask

   task automatic test_attack;
      logic [4:0]  n;
      logic [2:0]  k;
      logic [31:0] b;
      for (int i = 0; i < 8; i++) begin
         n = 5'(i * 9);
         k = 3'(i);
         b = (32'h2 * 32'(n) + 32'h1) * 32'h20;
         wr_chk(LAGC_ADDR_ATTACK, {24'h0, n, k}, 4'h1, LAGC_RESP_OKAY);
         settle();
         rd_chk(LAGC_ADDR_ATTACK, {24'h0, n, k}, LAGC_RESP_OKAY);
         chk("base", b, 32'(attack_base_wclk));
         chk("scale", 32'h1 << k, 32'(attack_scale));
         chk("eff", b << k, 32'(attack_eff_wclk));
      end
      $display("test_attack done");
   endtask

   // Unmapped places answer with an error and keep state unchanged
   task automatic test_bus;
      wr_chk(12'h168, 32'h55, 4'h1, LAGC_RESP_SLVERR);
      rd_chk(12'h168, 32'h0, LAGC_RESP_SLVERR);
      wr_chk(12'h15a, 32'h80, 4'h1, LAGC_RESP_SLVERR);
      wr_chk(LAGC_ADDR_ATTACK, 32'h0, 4'h0, LAGC_RESP_OKAY);
      rd_chk(LAGC_ADDR_ATTACK, 32'hff, LAGC_RESP_OKAY);
      rd_chk(LAGC_ADDR_CTRL_A, 32'hf3, LAGC_RESP_OKAY);
      $display("test_bus done");
   endtask

   initial begin
      err_count = 0;
      tests_run = 0;
      s_axi_awaddr = 12'h0;
      s_axi_araddr = 12'h0;
      s_axi_wdata = 32'h0;
      s_axi_wstrb = 4'h0;
      s_axi_awvalid = 1'b0;
      s_axi_wvalid = 1'b0;
      s_axi_bready = 1'b0;
      s_axi_arvalid = 1'b0;
      s_axi_rready = 1'b0;
      nrst = 1'b0;
      repeat (3) @(posedge sys_clk);
      nrst <= 1'b1;
      settle();
      test_reset();
      test_ctrl_a();
      test_ctrl_b();
      test_max_gain();
      test_attack();
      test_bus();
      test_done();
   end
endmodule
`default_nettype wire
